// ---- dv/fp_exec_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module fp_exec_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Instruction request
  input wire logic i_instr_valid,
  input wire fp_exec_pkg::op_t i_instr_op,
  input wire logic i_cond_pass,
  input wire logic i_privileged,
  input wire logic i_dbl,
  input wire logic [4:0] i_reg_count,
  input wire logic [31:0] i_base_value,
  input wire logic i_decrement_before,
  input wire logic i_imm_add,
  input wire logic [9:0] i_imm,
  input wire logic i_cps_disable,
  input wire logic i_cps_i,
  input wire logic i_cps_f,
  // Watched outputs
  input wire logic o_instr_ready,
  input wire logic o_base_wb_valid,
  input wire logic [31:0] o_base_wb_value,
  input wire logic o_mem_we,
  input wire logic o_mem_re,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_interrupt_mask_bit,
  input wire logic o_fault_mask_bit,
  input wire logic o_debug_halt
);
  // ------------------------------------------------
  // Accepted request and the addresses it implies
  // ------------------------------------------------
  wire take = i_instr_valid && o_instr_ready;
  wire go = take && i_cond_pass && (i_reg_count != 5'h00);
  wire is_pop = i_instr_op == fp_exec_pkg::OP_EXT_REG_POP;
  wire is_push = i_instr_op == fp_exec_pkg::OP_EXT_REG_PUSH;
  wire is_stm = i_instr_op == fp_exec_pkg::OP_FP_STORE_MULTIPLE;
  wire is_one = i_instr_op == fp_exec_pkg::OP_FP_STORE_SINGLE;
  wire is_cps = i_instr_op == fp_exec_pkg::OP_CHANGE_PROC_STATE;
  wire is_breakpoint_instr = i_instr_op == fp_exec_pkg::OP_BREAKPOINT_INSTR;
  wire [5:0] words = i_dbl ? {i_reg_count, 1'b0} : {1'b0, i_reg_count};
  wire [31:0] span = {24'h000000, words, 2'b00};
  wire [31:0] offs = {22'h000000, i_imm[9:2], 2'b00};
  logic [31:0] cap_base, cap_up, cap_dn, cap_st;
  // Captured at the taking edge; safe because nothing new is taken mid-transfer
  always_ff @(posedge i_clk) begin
    if (take) begin
      cap_base <= i_base_value;
      cap_up <= i_base_value + span;
      cap_dn <= i_base_value - span;
      cap_st <= i_imm_add ? i_base_value + offs : i_base_value - offs;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wb(logic [31:0] v);
    o_base_wb_valid && o_base_wb_value == v;
  endsequence
  sequence s_we(logic [31:0] ad);
    o_mem_we && o_mem_addr == ad;
  endsequence
  chk_pop_base: assert property (go && is_pop |=> s_wb(cap_up) ##1
    (o_mem_re && o_mem_addr == cap_base)) else $error("pop not read from base");
  chk_push_below: assert property (go && is_push |=> s_wb(cap_dn) ##1 s_we(cap_dn))
    else $error("push address or writeback wrong");
  chk_stm_db: assert property (go && is_stm && i_decrement_before
    |=> s_wb(cap_dn) ##1 s_we(cap_dn)) else $error("decrement-before store wrong");
  chk_stm_ia: assert property (go && is_stm && !i_decrement_before
    |=> ##1 s_we(cap_base)) else $error("increment-after store not at base");
  chk_single_addr: assert property (take && i_cond_pass && is_one
    |=> !o_base_wb_valid ##1 s_we(cap_st)) else $error("single store address wrong");
  chk_mask_priv: assert property (take && is_cps && i_privileged |=>
    o_interrupt_mask_bit == ($past(i_cps_i) ? $past(i_cps_disable) : $past(o_interrupt_mask_bit))
    && o_fault_mask_bit == ($past(i_cps_f) ? $past(i_cps_disable) : $past(o_fault_mask_bit)))
    else $error("mask bits not updated");
  chk_mask_unpriv: assert property (take && is_cps && !i_privileged |=>
    $stable(o_interrupt_mask_bit) && $stable(o_fault_mask_bit)) else $error("unprivileged change");
  chk_breakpoint_instr_halt: assert property (take && is_breakpoint_instr |=>
    (o_debug_halt && !o_instr_ready) [*2]) else $error("breakpoint did not halt");
endmodule
bind fp_exec fp_exec_asserts u_fp_exec_asserts (.i_clk, .i_rst_n, .i_instr_valid, .i_instr_op,
  .i_cond_pass, .i_privileged, .i_dbl, .i_reg_count, .i_base_value, .i_decrement_before,
  .i_imm_add, .i_imm, .i_cps_disable, .i_cps_i, .i_cps_f, .o_instr_ready, .o_base_wb_valid,
  .o_base_wb_value, .o_mem_we, .o_mem_re, .o_mem_addr, .o_interrupt_mask_bit,
  .o_fault_mask_bit, .o_debug_halt);
`default_nettype wire

// ---- dv/fp_exec_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module fp_exec_tb;
  // ------------------------------------------------
  // Signals, design and stack model
  // ------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst_n, i_instr_valid, i_cond_pass, i_privileged, i_dbl, i_writeback, i_imm_add;
  logic i_decrement_before, i_cps_disable, i_cps_i, i_cps_f, i_reg_wr, i_reg_rd;
  logic [4:0] i_first_reg, i_reg_count, i_dst_reg, i_src_n_reg, i_src_m_reg;
  logic [31:0] i_base_value, i_reg_wdata, i_mem_rdata, o_base_wb_value, o_mem_addr;
  logic [31:0] o_mem_wdata, o_reg_rdata, a;
  logic [9:0] i_imm;
  logic [7:0] i_reg_addr;
  fp_exec_pkg::op_t i_instr_op;
  logic o_instr_ready, o_base_wb_valid, o_mem_we, o_mem_re, o_debug_halt;
  logic o_interrupt_mask_bit, o_fault_mask_bit, rd_seen = 1'b0, im = 1'b0, fm = 1'b0;
  logic [63:0] m;
  logic [63:0] q_mem [$];
  logic [31:0] q_wb [$], q_rd [$], fpr [32];
  int err_count = 0, samples_checked = 0, cycles = 0, seed = 47370, k;
  // Popped words, then {subtract, n, m, result} rows writing S8 upwards
  logic [31:0] pre [8] = '{32'h40800000, 32'h41100000, 32'hBF800000, 32'h40200000,
    32'h3F800000, 32'h80000000, 32'h3E800000, 32'h7F800000};
  logic [42:0] alu [8] = '{43'h00140400000, 43'h0027FC00000, 43'h42040A00000, 43'h0063F000000,
    43'h00580000000, 43'h4643FC00000, 43'h4E77FC00000, 43'h0043F800000};
  fp_exec u_fp_exec (.i_clk, .i_rst_n, .i_instr_valid, .i_instr_op, .i_cond_pass, .i_privileged,
    .i_dbl, .i_first_reg, .i_reg_count, .i_dst_reg, .i_src_n_reg, .i_src_m_reg, .i_base_value,
    .i_writeback, .i_decrement_before, .i_imm_add, .i_imm, .i_cps_disable, .i_cps_i, .i_cps_f,
    .o_instr_ready, .o_base_wb_valid, .o_base_wb_value, .o_mem_we, .o_mem_re, .o_mem_addr,
    .o_mem_wdata, .i_mem_rdata, .o_interrupt_mask_bit, .o_fault_mask_bit, .o_debug_halt,
    .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);
  fp_mem_model u_fp_mem_model (.i_clk, .i_we(o_mem_we), .i_re(o_mem_re), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  always #10 i_clk = ~i_clk;
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic check(input string n, input logic [31:0] x, g);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  function automatic logic [31:0] stat(input logic h, f, i);
    return (32'(h) << fp_exec_pkg::STAT_DEBUG_BIT) | (32'(i) << fp_exec_pkg::STAT_INT_MASK_BIT) |
      (32'(f) << fp_exec_pkg::STAT_FAULT_MASK_BIT);
  endfunction
  // One register cycle; for a read, d is the expected data
  task automatic reg_rw(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= ad;
    i_reg_wdata <= d;
    if (w) i_reg_wr <= 1'b1;
    else begin
      i_reg_rd <= 1'b1;
      q_rd.push_back(d);
    end
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
  endtask
  // Ready is combinational, so it is sampled mid-cycle
  task automatic idle;
    repeat (2) @(posedge i_clk);
    for (int j = 0; j < 200; j++) begin
      @(negedge i_clk);
      if (o_instr_ready === 1'b1) break;
    end
    @(posedge i_clk);
  endtask
  task automatic ins(input fp_exec_pkg::op_t o, input logic [4:0] f, n, c, input logic [31:0] b);
    logic rdy;
    i_instr_op <= o;
    i_first_reg <= f;
    i_dst_reg <= f;
    i_reg_count <= n;
    i_src_n_reg <= n;
    i_src_m_reg <= c;
    i_base_value <= b;
    i_instr_valid <= 1'b1;
    do begin
      @(negedge i_clk);
      rdy = o_instr_ready;
      @(posedge i_clk);
    end while (rdy !== 1'b1);
    i_instr_valid <= 1'b0;
    if (o != fp_exec_pkg::OP_BREAKPOINT_INSTR) idle();
  endtask
  task automatic store(input fp_exec_pkg::op_t o, input logic d, input logic [4:0] f, c,
    input logic [31:0] b, ad, input logic w, input logic [31:0] wv);
    int sf = d ? 2 * f : f;
    int nw = d ? 2 * c : c;
    i_dbl <= d;
    for (int i = 0; i < nw; i++) q_mem.push_back({ad + 32'(4 * i), fpr[sf + i]});
    if (w) q_wb.push_back(wv);
    ins(o, f, c, 5'h00, b);
  endtask
  // Watcher: each result that appears takes the oldest note of its kind
  always @(posedge i_clk) begin
    rd_seen <= i_reg_rd;
    if (rd_seen) check("reg_rdata", q_rd.size() ? q_rd.pop_front() : 'x, o_reg_rdata);
    if (o_mem_we === 1'b1) begin
      m = q_mem.size() ? q_mem.pop_front() : 'x;
      check("mem_addr", m[63:32], o_mem_addr);
      check("mem_wdata", m[31:0], o_mem_wdata);
    end
    if (o_base_wb_valid === 1'b1)
      check("base_wb", q_wb.size() ? q_wb.pop_front() : 'x, o_base_wb_value);
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    i_rst_n <= 1'b0;
    i_cond_pass <= 1'b1;
    i_instr_op <= fp_exec_pkg::OP_NONE;
    {i_instr_valid, i_privileged, i_dbl, i_writeback, i_decrement_before, i_imm_add} <= '0;
    {i_cps_disable, i_cps_i, i_cps_f, i_reg_wr, i_reg_rd, i_base_value, i_reg_wdata} <= '0;
    {i_first_reg, i_reg_count, i_dst_reg, i_src_n_reg, i_src_m_reg, i_imm, i_reg_addr} <= '0;
    for (k = 0; k < 8; k++) u_fp_mem_model.mem[k] = pre[k];
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    reg_rw(1'b0, fp_exec_pkg::ADDR_FP_SEL, 32'h00000000);
    reg_rw(1'b0, 8'h10, 32'h00000000);
    q_wb.push_back(32'h00000020);
    ins(fp_exec_pkg::OP_EXT_REG_POP, 5'h00, 5'h08, 5'h00, 32'h00000000);
    for (k = 0; k < 8; k++) fpr[k] = pre[k];
    for (k = 0; k < 8; k++) begin
      ins(alu[k][42] ? fp_exec_pkg::OP_FP_SUBTRACT : fp_exec_pkg::OP_FP_SQUARE_ROOT,
        5'(8 + k), alu[k][41:37], alu[k][36:32], 32'h00000000);
      fpr[8 + k] = alu[k][31:0];
    end
    i_cond_pass <= 1'b0;
    ins(fp_exec_pkg::OP_FP_SUBTRACT, 5'h0A, 5'h00, 5'h01, 32'h00000000);
    i_cond_pass <= 1'b1;
    for (k = 0; k < 16; k++) begin
      reg_rw(1'b1, fp_exec_pkg::ADDR_FP_SEL, 32'(k));
      reg_rw(1'b0, fp_exec_pkg::ADDR_FP_DATA, fpr[k]);
    end
    {i_writeback, i_decrement_before} <= 2'b11;
    store(fp_exec_pkg::OP_EXT_REG_PUSH, 0, 8, 2, 32'h100, 32'hF8, 1, 32'hF8);
    store(fp_exec_pkg::OP_EXT_REG_PUSH, 0, 0, 16, 32'h400, 32'h3C0, 1, 32'h3C0);
    store(fp_exec_pkg::OP_FP_STORE_MULTIPLE, 1, 1, 1, 32'h300, 32'h2F8, 1, 32'h2F8);
    i_decrement_before <= 1'b0;
    store(fp_exec_pkg::OP_FP_STORE_MULTIPLE, 0, 0, 3, 32'h200, 32'h200, 1, 32'h20C);
    i_writeback <= 1'b0;
    store(fp_exec_pkg::OP_FP_STORE_MULTIPLE, 0, 10, 1, 32'h280, 32'h280, 0, 0);
    for (k = 0; k < 6; k++) begin
      a = k ? $random(seed) : 32'h000003FC;
      i_imm_add <= a[10];
      i_imm <= {a[9:2], 2'b00};
      store(fp_exec_pkg::OP_FP_STORE_SINGLE, a[11], 5'(k + 2), 1, 32'h800,
        a[10] ? 32'h800 + {a[9:2], 2'b00} : 32'h800 - {a[9:2], 2'b00}, 0, 0);
    end
    for (k = 0; k < 24; k++) begin
      a = $random(seed);
      {i_privileged, i_cps_disable, i_cps_i, i_cps_f} <= a[3:0];
      ins(fp_exec_pkg::OP_CHANGE_PROC_STATE, 5'h00, 5'h00, 5'h00, 32'h00000000);
      if (a[3] && a[1]) im = a[2];
      if (a[3] && a[0]) fm = a[2];
      reg_rw(1'b0, fp_exec_pkg::ADDR_STATUS, stat(1'b0, fm, im));
    end
    i_cond_pass <= 1'b0;
    ins(fp_exec_pkg::OP_BREAKPOINT_INSTR, 5'h00, 5'h00, 5'h00, 32'h00000000);
    reg_rw(1'b0, fp_exec_pkg::ADDR_STATUS, stat(1'b1, fm, im));
    reg_rw(1'b1, fp_exec_pkg::ADDR_CTRL, 32'h00000001 << fp_exec_pkg::CTRL_RESUME_BIT);
    idle();
    reg_rw(1'b0, fp_exec_pkg::ADDR_STATUS, stat(1'b0, fm, im));
    repeat (4) @(posedge i_clk);
    check("pending", 32'h00000000, 32'(q_mem.size() + q_wb.size() + q_rd.size()));
    stop_test();
  end
endmodule
`default_nettype wire

// ---- dv/fp_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module fp_mem_model (
  // Clock
  input wire logic i_clk,
  // Word port from the block
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  // ------------------------------------------------
  // Stack memory, 1 KiB window that wraps
  // ------------------------------------------------
  logic [31:0] mem [256];
  logic [31:0] rdata = 32'h5AC3A55C;
  assign o_rdata = rdata;
  // Data stands one cycle only; it flips after so a late sample never matches
  always @(posedge i_clk) begin
    if (i_we) mem[i_addr[9:2]] <= i_wdata;
    if (i_re) rdata <= mem[i_addr[9:2]];
    else rdata <= ~rdata;
  end
endmodule
`default_nettype wire

// ---- logic/fp_exec.sv ----
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Pop loads consecutive extension registers from successive stack words.
// - Push stores consecutive extension registers onto the stack, one to sixteen.
// - Square root of source register is written to destination register.
// - Store multiple: increment-after from base, or decrement-before ending below base.
// - Writeback stores the modified address to base; forced for decrement-before.
// - Single store address is base plus or minus word-multiple immediate.
// - Single store writes one single or double register; stack pointer base allowed.
// - Subtract places first operand minus second in the destination.
// - Breakpoint enters debug state; its immediate is ignored.
// - Breakpoint runs unconditionally in a conditional block; flags untouched.
// - Disable form sets, enable form clears the selected mask bits.
// - Mask change has no effect from unprivileged software.
module fp_exec (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Decoded instruction
  input wire logic i_instr_valid,
  input wire fp_exec_pkg::op_t i_instr_op,
  input wire logic i_cond_pass,
  input wire logic i_privileged,
  input wire logic i_dbl,
  input wire logic [4:0] i_first_reg,
  input wire logic [4:0] i_reg_count,
  input wire logic [4:0] i_dst_reg,
  input wire logic [4:0] i_src_n_reg,
  input wire logic [4:0] i_src_m_reg,
  input wire logic [31:0] i_base_value,
  input wire logic i_writeback,
  input wire logic i_decrement_before,
  input wire logic i_imm_add,
  input wire logic [9:0] i_imm,
  input wire logic i_cps_disable,
  input wire logic i_cps_i,
  input wire logic i_cps_f,
  output logic o_instr_ready,
  // Base register writeback
  output logic o_base_wb_valid,
  output logic [31:0] o_base_wb_value,
  // Data memory
  output logic o_mem_we,
  output logic o_mem_re,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic [31:0] i_mem_rdata,
  // System state
  output logic o_interrupt_mask_bit,
  output logic o_fault_mask_bit,
  output logic o_debug_halt,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] fp_reg [0:31];
  fp_exec_pkg::state_t state;
  logic [5:0] xfer_left;
  logic [4:0] xfer_idx, mem_idx, rd_idx, sq_step, sq_dst, fp_sel;
  logic [31:0] xfer_addr;
  logic rd_valid;
  logic [49:0] sq_rad;
  logic [27:0] sq_rem;
  logic [24:0] sq_root;
  logic [7:0] sq_exp;

  // ----------------------------------------------------------------
  // Instruction acceptance and address forming
  // ----------------------------------------------------------------
  // Loads in flight hold off new work so the register write port stays single
  assign o_instr_ready = (state == fp_exec_pkg::ST_IDLE) && !o_mem_re && !rd_valid && !o_debug_halt;
  wire accept = i_instr_valid && o_instr_ready;
  wire exec = accept && i_cond_pass;
  wire op_pop = i_instr_op == fp_exec_pkg::OP_EXT_REG_POP;
  wire op_push = i_instr_op == fp_exec_pkg::OP_EXT_REG_PUSH;
  wire op_stm = i_instr_op == fp_exec_pkg::OP_FP_STORE_MULTIPLE;
  wire op_str = i_instr_op == fp_exec_pkg::OP_FP_STORE_SINGLE;
  wire op_sqrt = i_instr_op == fp_exec_pkg::OP_FP_SQUARE_ROOT;
  wire op_sub = i_instr_op == fp_exec_pkg::OP_FP_SUBTRACT;
  wire op_breakpoint_instr = i_instr_op == fp_exec_pkg::OP_BREAKPOINT_INSTR;
  wire op_cps = i_instr_op == fp_exec_pkg::OP_CHANGE_PROC_STATE;
  // Doubleword n is the pair of singlewords 2n and 2n+1, so all moves are in words
  wire [5:0] list_words = i_dbl ? {i_reg_count, 1'b0} : {1'b0, i_reg_count};
  wire [5:0] words = op_str ? (i_dbl ? 6'h02 : 6'h01) : list_words;
  wire [4:0] first_s = i_dbl ? {i_first_reg[3:0], 1'b0} : i_first_reg;
  wire [31:0] span = {24'h000000, words, 2'b00};
  wire [31:0] base_up = i_base_value + span;
  wire [31:0] base_down = i_base_value - span;
  wire [31:0] imm_off = {22'h000000, i_imm[9:2], 2'b00};
  wire [31:0] str_addr = i_imm_add ? i_base_value + imm_off : i_base_value - imm_off;
  wire dec_mode = op_push || (op_stm && i_decrement_before);
  wire [31:0] start_addr = op_str ? str_addr : (dec_mode ? base_down : i_base_value);
  wire wb_req = op_push || op_pop || (op_stm && (i_writeback || i_decrement_before));
  wire is_store = op_push || op_stm || op_str;

  // ----------------------------------------------------------------
  // Subtract datapath
  // ----------------------------------------------------------------
  wire [31:0] sub_a = fp_reg[i_src_n_reg];
  wire [31:0] sub_b = fp_reg[i_src_m_reg] ^ fp_exec_pkg::SIGN_BIT;
  logic [31:0] sub_res;
  // Subnormal inputs and outputs are flushed to zero to keep the adder small
  always_comb begin
    logic a_big, sx, sy, up;
    logic [7:0] ex, ey, d;
    logic [22:0] fx, fy;
    logic [26:0] xs, ys, al, n;
    logic [27:0] sum;
    logic [4:0] lz;
    logic [9:0] e;
    logic [24:0] mr;
    n = 27'h0000000;
    e = 10'h000;
    a_big = sub_a[30:23] != 8'h00 && sub_a[30:0] >= sub_b[30:0];
    a_big = a_big || sub_b[30:23] == 8'h00;
    sx = a_big ? sub_a[31] : sub_b[31];
    sy = a_big ? sub_b[31] : sub_a[31];
    ex = a_big ? sub_a[30:23] : sub_b[30:23];
    ey = a_big ? sub_b[30:23] : sub_a[30:23];
    fx = a_big ? sub_a[22:0] : sub_b[22:0];
    fy = a_big ? sub_b[22:0] : sub_a[22:0];
    if (ex == 8'h00) fx = 23'h000000;
    if (ey == 8'h00) fy = 23'h000000;
    d = ex - ey;
    xs = {ex != 8'h00, fx, 3'b000};
    ys = {ey != 8'h00, fy, 3'b000};
    al = ys >> d;
    al[0] = al[0] | (|(ys & ~(27'h7FFFFFF << d)));
    sum = (sx == sy) ? {1'b0, xs} + {1'b0, al} : {1'b0, xs} - {1'b0, al};
    lz = 5'h1B;
    for (int k = 0; k < 27; k++) begin
      if (sum[k]) lz = 5'(26 - k);
    end
    if (sum[27]) begin
      n = {sum[27:2], sum[1] | sum[0]};
      e = {2'b00, ex} + 10'h001;
    end else begin
      n = sum[26:0] << lz;
      e = {2'b00, ex} - {5'h00, lz};
    end
    up = n[2] & (n[1] | n[0] | n[3]);
    mr = {1'b0, n[26:3]} + {24'h000000, up};
    if (mr[24]) e = e + 10'h001;
    // Specials first, then the normal path
    if ((sub_a[30:23] == fp_exec_pkg::EXP_ALL_ONES && sub_a[22:0] != 23'h0) ||
        (sub_b[30:23] == fp_exec_pkg::EXP_ALL_ONES && sub_b[22:0] != 23'h0)) begin
      sub_res = fp_exec_pkg::QNAN;
    end else if (ex == fp_exec_pkg::EXP_ALL_ONES) begin
      sub_res = (ey == fp_exec_pkg::EXP_ALL_ONES && sx != sy) ? fp_exec_pkg::QNAN :
                {sx, ex, 23'h000000};
    end else if (sum == 28'h0) begin
      sub_res = (sx == sy) ? {sx, 31'h00000000} : 32'h00000000;
    end else if (!e[9] && e[8:0] >= 9'h0FF) begin
      sub_res = {sx, fp_exec_pkg::EXP_ALL_ONES, 23'h000000};
    end else if (e[9] || e == 10'h000) begin
      sub_res = {sx, 31'h00000000};
    end else begin
      sub_res = {sx, e[7:0], mr[24] ? mr[23:1] : mr[22:0]};
    end
  end

  // ----------------------------------------------------------------
  // Square root entry checks and iteration step
  // ----------------------------------------------------------------
  wire [31:0] sq_src = fp_reg[i_src_m_reg];
  wire sq_zero = sq_src[30:23] == 8'h00;
  wire sq_top = sq_src[30:23] == fp_exec_pkg::EXP_ALL_ONES;
  wire sq_special = sq_zero || sq_top || sq_src[31];
  // Negative nonzero and NaN give NaN, zero keeps its sign, +inf stays
  wire [31:0] sq_special_res = sq_zero ? {sq_src[31], 31'h00000000} :
                               (sq_top && sq_src[22:0] == 23'h0 && !sq_src[31]) ? sq_src :
                               fp_exec_pkg::QNAN;
  // Even unbiased exponent when the biased one is odd
  wire [49:0] sq_rad_init = sq_src[23] ? {1'b0, 1'b1, sq_src[22:0], 25'h0} :
                            {1'b1, sq_src[22:0], 26'h0};
  wire [8:0] sq_exp_sum = {1'b0, sq_src[30:23]} + fp_exec_pkg::EXP_BIAS;
  // One result bit per cycle trades latency for a tiny restoring datapath
  wire [27:0] sq_rem_sh = {sq_rem[25:0], sq_rad[49:48]};
  wire [27:0] sq_trial = {1'b0, sq_root, 2'b01};
  wire sq_fit = sq_rem_sh >= sq_trial;
  wire sq_up = sq_root[0] & ((sq_rem != 28'h0) | sq_root[1]);
  wire [24:0] sq_mr = {1'b0, sq_root[24:1]} + {24'h000000, sq_up};
  wire [31:0] sq_final = {1'b0, sq_exp + {7'h00, sq_mr[24]}, sq_mr[24] ? sq_mr[23:1] : sq_mr[22:0]};
  wire sq_done = (state == fp_exec_pkg::ST_SQRT) && (sq_step == fp_exec_pkg::SQRT_STEPS);

  // ----------------------------------------------------------------
  // Register file write port
  // ----------------------------------------------------------------
  wire wr_sub = exec && op_sub;
  wire wr_sq_special = exec && op_sqrt && sq_special;
  always_ff @(posedge i_clk) begin
    if (rd_valid) begin
      fp_reg[rd_idx] <= i_mem_rdata;
    end else if (sq_done) begin
      fp_reg[sq_dst] <= sq_final;
    end else if (wr_sq_special) begin
      fp_reg[i_dst_reg] <= sq_special_res;
    end else if (wr_sub) begin
      fp_reg[i_dst_reg] <= sub_res;
    end
  end

  // ----------------------------------------------------------------
  // Transfer and square root sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= fp_exec_pkg::ST_IDLE;
      xfer_left <= 6'h00;
      xfer_idx <= 5'h00;
      xfer_addr <= 32'h00000000;
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      o_mem_addr <= 32'h00000000;
      o_mem_wdata <= 32'h00000000;
      mem_idx <= 5'h00;
      rd_valid <= 1'b0;
      rd_idx <= 5'h00;
      o_base_wb_valid <= 1'b0;
      o_base_wb_value <= 32'h00000000;
      sq_rad <= 50'h0;
      sq_rem <= 28'h0;
      sq_root <= 25'h0;
      sq_step <= 5'h00;
      sq_exp <= 8'h00;
      sq_dst <= 5'h00;
    end else begin
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      o_base_wb_valid <= 1'b0;
      rd_valid <= o_mem_re;
      rd_idx <= mem_idx;
      case (state)
        fp_exec_pkg::ST_IDLE: begin
          if (exec && (is_store || op_pop) && words != 6'h00) begin
            state <= is_store ? fp_exec_pkg::ST_STORE : fp_exec_pkg::ST_LOAD;
            xfer_left <= words;
            xfer_idx <= op_str ? (i_dbl ? {i_first_reg[3:0], 1'b0} : i_first_reg) : first_s;
            xfer_addr <= start_addr;
            o_base_wb_valid <= wb_req;
            o_base_wb_value <= dec_mode ? base_down : base_up;
          end else if (exec && op_sqrt && !sq_special) begin
            state <= fp_exec_pkg::ST_SQRT;
            sq_rad <= sq_rad_init;
            sq_rem <= 28'h0;
            sq_root <= 25'h0;
            sq_step <= 5'h00;
            sq_exp <= sq_exp_sum[8:1];
            sq_dst <= i_dst_reg;
          end
        end
        fp_exec_pkg::ST_STORE: begin
          o_mem_we <= 1'b1;
          o_mem_addr <= xfer_addr;
          o_mem_wdata <= fp_reg[xfer_idx];
          xfer_addr <= xfer_addr + fp_exec_pkg::WORD_BYTES;
          xfer_idx <= xfer_idx + 5'h01;
          xfer_left <= xfer_left - 6'h01;
          if (xfer_left == 6'h01) state <= fp_exec_pkg::ST_IDLE;
        end
        fp_exec_pkg::ST_LOAD: begin
          o_mem_re <= 1'b1;
          o_mem_addr <= xfer_addr;
          mem_idx <= xfer_idx;
          xfer_addr <= xfer_addr + fp_exec_pkg::WORD_BYTES;
          xfer_idx <= xfer_idx + 5'h01;
          xfer_left <= xfer_left - 6'h01;
          if (xfer_left == 6'h01) state <= fp_exec_pkg::ST_IDLE;
        end
        fp_exec_pkg::ST_SQRT: begin
          if (sq_done) begin
            state <= fp_exec_pkg::ST_IDLE;
          end else begin
            sq_rad <= {sq_rad[47:0], 2'b00};
            sq_rem <= sq_fit ? sq_rem_sh - sq_trial : sq_rem_sh;
            sq_root <= {sq_root[23:0], sq_fit};
            sq_step <= sq_step + 5'h01;
          end
        end
        default: state <= fp_exec_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mask bits and debug state
  // ----------------------------------------------------------------
  // Neither breakpoint nor mask change looks at the condition; flags are never driven here
  wire cps_ok = accept && op_cps && i_privileged;
  wire breakpoint_instr_hit = accept && op_breakpoint_instr;
  wire resume = i_reg_wr && i_reg_addr == fp_exec_pkg::ADDR_CTRL &&
                i_reg_wdata[fp_exec_pkg::CTRL_RESUME_BIT];
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_interrupt_mask_bit <= fp_exec_pkg::RST_MASK;
      o_fault_mask_bit <= fp_exec_pkg::RST_MASK;
      o_debug_halt <= 1'b0;
    end else begin
      if (cps_ok && i_cps_i) o_interrupt_mask_bit <= i_cps_disable;
      if (cps_ok && i_cps_f) o_fault_mask_bit <= i_cps_disable;
      if (breakpoint_instr_hit) o_debug_halt <= 1'b1;
      else if (resume) o_debug_halt <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire busy = !o_instr_ready && !o_debug_halt;
  wire [31:0] status_word = {28'h0000000, busy, o_debug_halt, o_fault_mask_bit,
                             o_interrupt_mask_bit};
  wire [31:0] rd_mux = (i_reg_addr == fp_exec_pkg::ADDR_STATUS) ? status_word :
                       (i_reg_addr == fp_exec_pkg::ADDR_FP_SEL) ? {27'h0, fp_sel} :
                       (i_reg_addr == fp_exec_pkg::ADDR_FP_DATA) ? fp_reg[fp_sel] :
                       32'h00000000;
  // Control reads as zero since resume is a self-clearing command
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fp_sel <= fp_exec_pkg::RST_FP_SEL;
      o_reg_rdata <= 32'h00000000;
    end else begin
      if (i_reg_wr && i_reg_addr == fp_exec_pkg::ADDR_FP_SEL) fp_sel <= i_reg_wdata[4:0];
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ---- logic/fp_exec_pkg.sv ----
package fp_exec_pkg;
  // ----------------------------------------------------------------
  // Decoded operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_EXT_REG_POP,
    OP_EXT_REG_PUSH,
    OP_FP_SQUARE_ROOT,
    OP_FP_STORE_MULTIPLE,
    OP_FP_STORE_SINGLE,
    OP_FP_SUBTRACT,
    OP_BREAKPOINT_INSTR,
    OP_CHANGE_PROC_STATE
  } op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_STORE, ST_LOAD, ST_SQRT} state_t;
  // ----------------------------------------------------------------
  // Register port map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FP_SEL = 8'h08;
  localparam logic [7:0] ADDR_FP_DATA = 8'h0C;
  localparam int CTRL_RESUME_BIT = 0;
  localparam int STAT_INT_MASK_BIT = 0;
  localparam int STAT_FAULT_MASK_BIT = 1;
  localparam int STAT_DEBUG_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam logic RST_MASK = 1'b0;
  localparam logic [4:0] RST_FP_SEL = 5'h00;
  // ----------------------------------------------------------------
  // Floating-point constants and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] QNAN = 32'h7FC00000;
  localparam logic [31:0] SIGN_BIT = 32'h80000000;
  localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
  localparam logic [8:0] EXP_BIAS = 9'h07F;
  localparam logic [4:0] SQRT_STEPS = 5'h19;
  localparam logic [31:0] WORD_BYTES = 32'h00000004;
endpackage
